/* include/gpio_pkg.sv */
package gpio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int GPIO_NP      = 5;
  localparam int GPIO_NPIN    = 8;
  localparam int GPIO_NF      = 4;
  localparam int GPIO_AW      = 15;
  localparam int GPIO_PORT_LSB = 12;
  localparam int GPIO_MASK_LSB = 2;
  localparam int GPIO_PCTL_W   = 4;
  localparam int GPIO_ADC_PORT = 1;
  localparam int GPIO_ADC_PIN  = 4;

  // ----------------------------------------------------------------
  // Register offsets inside one port window
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DATA_END = 12'h03FC;
  localparam logic [11:0] OFF_DIR      = 12'h0400;
  localparam logic [11:0] OFF_ISENSE   = 12'h0404;
  localparam logic [11:0] OFF_IBOTH    = 12'h0408;
  localparam logic [11:0] OFF_IEVENT   = 12'h040C;
  localparam logic [11:0] OFF_IMASK    = 12'h0410;
  localparam logic [11:0] OFF_ISTAT    = 12'h0414;
  localparam logic [11:0] OFF_IMSTAT   = 12'h0418;
  localparam logic [11:0] OFF_AFSEL    = 12'h0420;
  localparam logic [11:0] OFF_DRIVE    = 12'h0500;
  localparam logic [11:0] OFF_ODRAIN   = 12'h050C;
  localparam logic [11:0] OFF_PULLUP   = 12'h0510;
  localparam logic [11:0] OFF_PULLDN   = 12'h0514;
  localparam logic [11:0] OFF_SLEW     = 12'h0518;
  localparam logic [11:0] OFF_DEN      = 12'h051C;
  localparam logic [11:0] OFF_PCTL     = 12'h052C;

  // ----------------------------------------------------------------
  // Drive strength codes, two bits per pin
  // ----------------------------------------------------------------
  localparam logic [1:0] DRV_2MA = 2'h0;
  localparam logic [1:0] DRV_4MA = 2'h1;
  localparam logic [1:0] DRV_8MA = 2'h2;

  // ----------------------------------------------------------------
  // Reset values, port E down to port A
  // ----------------------------------------------------------------
  localparam logic [GPIO_NP-1:0][7:0]  AFSEL_RST = {8'h00, 8'h00, 8'h0F, 8'h0C, 8'h3F};
  localparam logic [GPIO_NP-1:0][7:0]  DEN_RST   = {8'h00, 8'h00, 8'h0F, 8'h0C, 8'h3F};
  localparam logic [GPIO_NP-1:0][7:0]  PUR_RST   = {8'h00, 8'h00, 8'h0F, 8'h00, 8'h00};
  localparam logic [GPIO_NP-1:0][7:0]  PDR_RST   = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [GPIO_NP-1:0][31:0] PCTL_RST  = {32'h0000_0000, 32'h0000_0000,
                                                    32'h0000_3333, 32'h0000_1100,
                                                    32'h0011_1111};

  typedef struct packed {
    logic       analog;
    logic       pull_up;
    logic       pull_down;
    logic       open_drain;
    logic       slew;
    logic [1:0] drive;
  } gpio_pad_cfg_t;

endpackage : gpio_pkg

/* rtl/gpio_port_ctl.sv */
`timescale 1ns/1ns
module gpio_port_ctl
  import gpio_pkg::*;
#(
  parameter int NP = GPIO_NP,
  parameter int NF = GPIO_NF
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 resetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [GPIO_AW-1:0]                   paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic [NP-1:0][GPIO_NPIN-1:0]         pad_in,
  output logic      [NP-1:0][GPIO_NPIN-1:0]         pad_out,
  output logic      [NP-1:0][GPIO_NPIN-1:0]         pad_oe_n,
  output gpio_pad_cfg_t [NP-1:0][GPIO_NPIN-1:0]     pad_cfg,
  input  wire logic [NP-1:0][GPIO_NPIN-1:0][NF-1:0] periph_out,
  input  wire logic [NP-1:0][GPIO_NPIN-1:0][NF-1:0] periph_oe,
  output logic      [NP-1:0][GPIO_NPIN-1:0]         periph_in,
  output logic      [NP-1:0]                        irq,
  output logic                                      adc_trig
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NP-1:0][7:0]  data_q, data_d, dir_q, dir_d, isense_q, isense_d;
  logic [NP-1:0][7:0]  iboth_q, iboth_d, ievent_q, ievent_d, imask_q, imask_d;
  logic [NP-1:0][7:0]  istat_q, istat_d, afsel_q, afsel_d, den_q, den_d;
  logic [NP-1:0][7:0]  odr_q, odr_d, pur_q, pur_d, pdr_q, pdr_d, slr_q, slr_d;
  logic [NP-1:0][15:0] drv_q, drv_d;
  logic [NP-1:0][31:0] pctl_q, pctl_d;
  logic [NP-1:0][7:0]  sync1_q, sync2_q, prev_q, sync1_d;
  logic [NP-1:0][7:0]  pad_out_d, pad_oe_n_d, periph_in_d, ev_set;
  gpio_pad_cfg_t [NP-1:0][GPIO_NPIN-1:0] pad_cfg_d;
  logic [NP-1:0]       irq_d;
  logic [31:0]         prdata_d;
  logic                pready_d, pslverr_d, adc_trig_d, setup, wr_en;
  logic [11:0]         off;
  logic [7:0]          amask;
  int                  port;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && addr_ok(paddr);
  assign off   = paddr[GPIO_PORT_LSB-1:0];
  assign amask = paddr[GPIO_MASK_LSB+7:GPIO_MASK_LSB];
  assign port  = int'(paddr[GPIO_AW-1:GPIO_PORT_LSB]);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [GPIO_AW-1:0] a);
    logic [11:0] o;
    o = a[GPIO_PORT_LSB-1:0];
    addr_ok = 1'b0;
    if (int'(a[GPIO_AW-1:GPIO_PORT_LSB]) < NP && o[1:0] == 2'h0) begin
      case (o)
        OFF_DIR, OFF_ISENSE, OFF_IBOTH, OFF_IEVENT, OFF_IMASK, OFF_ISTAT,
        OFF_IMSTAT, OFF_AFSEL, OFF_DRIVE, OFF_ODRAIN, OFF_PULLUP, OFF_PULLDN,
        OFF_SLEW, OFF_DEN, OFF_PCTL: addr_ok = 1'b1;
        default: addr_ok = (o <= OFF_DATA_END);
      endcase
    end
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // APB slave: zero wait, read data sampled in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d  = prdata;
    pready_d  = setup;
    pslverr_d = setup && !addr_ok(paddr);
    if (setup) begin
      prdata_d = 32'h0000_0000;
      if (addr_ok(paddr)) begin
        case (off)
          OFF_DIR:    prdata_d[7:0] = dir_q[port];
          OFF_ISENSE: prdata_d[7:0] = isense_q[port];
          OFF_IBOTH:  prdata_d[7:0] = iboth_q[port];
          OFF_IEVENT: prdata_d[7:0] = ievent_q[port];
          OFF_IMASK:  prdata_d[7:0] = imask_q[port];
          OFF_ISTAT:  prdata_d[7:0] = istat_q[port];
          OFF_IMSTAT: prdata_d[7:0] = istat_q[port] & imask_q[port];
          OFF_AFSEL:  prdata_d[7:0] = afsel_q[port];
          OFF_DRIVE:  prdata_d[15:0] = drv_q[port];
          OFF_ODRAIN: prdata_d[7:0] = odr_q[port];
          OFF_PULLUP: prdata_d[7:0] = pur_q[port];
          OFF_PULLDN: prdata_d[7:0] = pdr_q[port];
          OFF_SLEW:   prdata_d[7:0] = slr_q[port];
          OFF_DEN:    prdata_d[7:0] = den_q[port];
          OFF_PCTL:   prdata_d = pctl_q[port];
          default:    prdata_d[7:0] = data_q[port] & amask;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration and interrupt registers
  // ----------------------------------------------------------------
  always_comb begin
    data_d = data_q;   dir_d = dir_q;     isense_d = isense_q; iboth_d = iboth_q;
    ievent_d = ievent_q; imask_d = imask_q; afsel_d = afsel_q; den_d = den_q;
    odr_d = odr_q;     pur_d = pur_q;     pdr_d = pdr_q;       slr_d = slr_q;
    drv_d = drv_q;     pctl_d = pctl_q;   istat_d = istat_q;
    if (wr_en) begin
      case (off)
        OFF_DIR:    dir_d[port]    = pwdata[7:0];
        OFF_ISENSE: isense_d[port] = pwdata[7:0];
        OFF_IBOTH:  iboth_d[port]  = pwdata[7:0];
        OFF_IEVENT: ievent_d[port] = pwdata[7:0];
        OFF_IMASK:  imask_d[port]  = pwdata[7:0];
        OFF_ISTAT:  istat_d[port]  = istat_q[port] & ~pwdata[7:0];
        OFF_IMSTAT: ;
        OFF_AFSEL:  afsel_d[port]  = pwdata[7:0];
        OFF_DRIVE:  drv_d[port]    = pwdata[15:0];
        OFF_ODRAIN: odr_d[port]    = pwdata[7:0];
        OFF_PULLUP: pur_d[port]    = pwdata[7:0];
        OFF_PULLDN: pdr_d[port]    = pwdata[7:0];
        OFF_SLEW:   slr_d[port]    = pwdata[7:0];
        OFF_DEN:    den_d[port]    = pwdata[7:0];
        OFF_PCTL:   pctl_d[port]   = pwdata;
        default:    data_d[port]   = (data_q[port] & ~amask) | (pwdata[7:0] & amask);
      endcase
    end
    for (int p = 0; p < NP; p++) begin
      // Input pins follow the synchronised pad; a write to them is overrun
      data_d[p] = (data_d[p] & dir_q[p]) | (sync2_q[p] & ~dir_q[p]);
      // Hardware set wins over a clear in the same cycle
      istat_d[p] = istat_d[p] | ev_set[p];
      irq_d[p]   = |(istat_d[p] & imask_q[p]);
    end
    adc_trig_d = istat_d[GPIO_ADC_PORT][GPIO_ADC_PIN] & imask_q[GPIO_ADC_PORT][GPIO_ADC_PIN];
  end

  // ----------------------------------------------------------------
  // Input path and interrupt detection
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      sync1_d[p] = pad_in[p] & den_q[p];
      ev_set[p]  = (isense_q[p] & ~(sync2_q[p] ^ ievent_q[p]))
                 | (~isense_q[p] & iboth_q[p] & (sync2_q[p] ^ prev_q[p]))
                 | (~isense_q[p] & ~iboth_q[p] & ievent_q[p] & sync2_q[p] & ~prev_q[p])
                 | (~isense_q[p] & ~iboth_q[p] & ~ievent_q[p] & ~sync2_q[p] & prev_q[p]);
    end
  end

  // ----------------------------------------------------------------
  // Pad output mux and pad settings
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] code;
    logic       o, e, alt;
    code = 4'h0;
    o    = 1'b0;
    e    = 1'b0;
    alt  = 1'b0;
    for (int p = 0; p < NP; p++) begin
      for (int i = 0; i < GPIO_NPIN; i++) begin
        code = pctl_q[p][i*GPIO_PCTL_W +: GPIO_PCTL_W];
        alt  = afsel_q[p][i] & den_q[p][i];
        if (alt) begin
          o = 1'b0;
          e = 1'b0;
          if (code != 4'h0 && int'(code) <= NF) begin
            o = periph_out[p][i][int'(code) - 1];
            e = periph_oe[p][i][int'(code) - 1];
          end
        end else begin
          o = data_q[p][i];
          e = dir_q[p][i];
        end
        // Open drain only ever pulls low
        e = e & ~(odr_q[p][i] & o) & den_q[p][i];
        pad_out_d[p][i]   = o & ~odr_q[p][i];
        pad_oe_n_d[p][i]  = ~e;
        periph_in_d[p][i] = alt & sync2_q[p][i];
        pad_cfg_d[p][i].analog     = ~den_q[p][i];
        pad_cfg_d[p][i].pull_up    = pur_q[p][i];
        pad_cfg_d[p][i].pull_down  = pdr_q[p][i];
        pad_cfg_d[p][i].open_drain = odr_q[p][i];
        pad_cfg_d[p][i].drive      = drv_q[p][2*i +: 2];
        pad_cfg_d[p][i].slew       = slr_q[p][i] & (drv_q[p][2*i +: 2] == DRV_8MA);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      afsel_q  <= AFSEL_RST;
      den_q    <= DEN_RST;
      pur_q    <= PUR_RST;
      pdr_q    <= PDR_RST;
      pctl_q   <= PCTL_RST;
      data_q   <= '0;
      dir_q    <= '0;
      isense_q <= '0;
      iboth_q  <= '0;
      ievent_q <= '0;
      imask_q  <= '0;
      istat_q  <= '0;
      odr_q    <= '0;
      slr_q    <= '0;
      drv_q    <= '0;
      sync1_q  <= '0;
      sync2_q  <= '0;
      prev_q   <= '0;
      pad_out  <= '0;
      pad_oe_n <= '1;
      pad_cfg  <= '0;
      periph_in <= '0;
      irq      <= '0;
      adc_trig <= 1'b0;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      afsel_q  <= afsel_d;
      den_q    <= den_d;
      pur_q    <= pur_d;
      pdr_q    <= pdr_d;
      pctl_q   <= pctl_d;
      data_q   <= data_d;
      dir_q    <= dir_d;
      isense_q <= isense_d;
      iboth_q  <= iboth_d;
      ievent_q <= ievent_d;
      imask_q  <= imask_d;
      istat_q  <= istat_d;
      odr_q    <= odr_d;
      slr_q    <= slr_d;
      drv_q    <= drv_d;
      sync1_q  <= sync1_d;
      sync2_q  <= sync1_q;
      prev_q   <= sync2_q;
      pad_out  <= pad_out_d;
      pad_oe_n <= pad_oe_n_d;
      pad_cfg  <= pad_cfg_d;
      periph_in <= periph_in_d;
      irq      <= irq_d;
      adc_trig <= adc_trig_d;
      prdata   <= prdata_d;
      pready   <= pready_d;
      pslverr  <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_out_toggle;
    wr_en && port == 3 && paddr[GPIO_MASK_LSB+1] && off <= OFF_DATA_END
      && dir_q[3][1] && !afsel_q[3][1] && den_q[3][1] && !odr_q[3][1]
      |=> ##1 pad_out[3][1] == $past(pwdata[1], 2);
  endproperty
  a_out_toggle: assert property (p_out_toggle) else $error("data write not on pad");

  property p_edge_irq;
    !isense_q[1][4] && iboth_q[1][4] && (sync2_q[1][4] != prev_q[1][4]) |=> istat_q[1][4];
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge not latched");

  property p_level_irq;
    isense_q[1][4] && (sync2_q[1][4] == ievent_q[1][4])
      |=> istat_q[1][4] ##1 (irq[1] || !$past(imask_q[1][4]));
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level not latched");

  property p_masked_read;
    setup && !pwrite && port == 3 && off <= OFF_DATA_END && !paddr[GPIO_MASK_LSB+1]
      |=> prdata[1] == 1'b0 && pready;
  endproperty
  a_masked_read: assert property (p_masked_read) else $error("masked bit read as one");

  property p_adc_trig;
    istat_q[GPIO_ADC_PORT][GPIO_ADC_PIN] && imask_q[GPIO_ADC_PORT][GPIO_ADC_PIN]
      && !wr_en |=> adc_trig;
  endproperty
  a_adc_trig: assert property (p_adc_trig) else $error("no adc trigger");

  property p_den_release;
    !den_q[3][0] |=> pad_oe_n[3][0] && pad_cfg[3][0].analog;
  endproperty
  a_den_release: assert property (p_den_release) else $error("driver not released");

  property p_alt_drive;
    afsel_q[3][0] && den_q[3][0] && pctl_q[3][3:0] == 4'h2 && !odr_q[3][0]
      |=> pad_out[3][0] == $past(periph_out[3][0][1]);
  endproperty
  a_alt_drive: assert property (p_alt_drive) else $error("peripheral not on pad");

  property p_capture;
    !dir_q[0][0] |=> data_q[0][0] == $past(sync2_q[0][0]);
  endproperty
  a_capture: assert property (p_capture) else $error("input not captured");

  property p_reset_cfg;
    @(posedge core_clk) disable iff (1'b0) !resetn |=> afsel_q == AFSEL_RST && pctl_q == PCTL_RST;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("reset defaults wrong");

  c_edge_irq: cover property (irq[1] && !isense_q[1][4]);
  c_adc:      cover property (adc_trig);
  c_err:      cover property (pslverr);

endmodule : gpio_port_ctl

/* tb/gpio_pad_model.sv */
`timescale 1ns/1ns
module gpio_pad_model
  import gpio_pkg::*;
(
  input  wire logic                                     core_clk,
  input  wire logic          [GPIO_NP-1:0][GPIO_NPIN-1:0] pad_out,
  input  wire logic          [GPIO_NP-1:0][GPIO_NPIN-1:0] pad_oe_n,
  input  wire gpio_pad_cfg_t [GPIO_NP-1:0][GPIO_NPIN-1:0] pad_cfg,
  input  wire logic          [GPIO_NP-1:0][GPIO_NPIN-1:0] ext_val,
  input  wire logic          [GPIO_NP-1:0][GPIO_NPIN-1:0] ext_en,
  output logic               [GPIO_NP-1:0][GPIO_NPIN-1:0] pad_in
);
  logic [GPIO_NP-1:0][GPIO_NPIN-1:0] float_q = '0;

  // Undriven, unpulled pads wander so that no stale level looks valid
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int p = 0; p < GPIO_NP; p++) begin
      for (int b = 0; b < GPIO_NPIN; b++) begin
        if (!pad_oe_n[p][b]) begin
          pad_in[p][b] = pad_out[p][b];
        end else if (ext_en[p][b]) begin
          pad_in[p][b] = ext_val[p][b];
        end else if (pad_cfg[p][b].pull_up) begin
          pad_in[p][b] = 1'b1;
        end else if (pad_cfg[p][b].pull_down) begin
          pad_in[p][b] = 1'b0;
        end else begin
          pad_in[p][b] = float_q[p][b];
        end
      end
    end
  end
endmodule : gpio_pad_model

/* tb/tb_gpio_port_pin_function_config.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_gpio_port_pin_function_config;
  import gpio_pkg::*;
  typedef struct packed {
    logic [2:0]  port;
    logic [11:0] off;
    logic [31:0] exp;
    logic        err;
  } gpio_row_t;
  logic                                        core_clk = 0;
  logic                                        resetn = 0;
  logic                                        psel = 0;
  logic                                        penable = 0;
  logic                                        pwrite = 0;
  logic          [GPIO_AW-1:0]                 paddr = '0;
  logic          [31:0]                        pwdata = '0;
  logic          [31:0]                        prdata;
  logic                                        pready;
  logic                                        pslverr;
  logic                                        adc_trig;
  logic          [GPIO_NP-1:0][GPIO_NPIN-1:0]  pad_in, pad_out, pad_oe_n, periph_in;
  logic          [GPIO_NP-1:0][GPIO_NPIN-1:0]  ext_val = '0, ext_en = '0;
  gpio_pad_cfg_t [GPIO_NP-1:0][GPIO_NPIN-1:0]  pad_cfg;
  logic [GPIO_NP-1:0][GPIO_NPIN-1:0][GPIO_NF-1:0] periph_out = '0, periph_oe = '0;
  logic          [GPIO_NP-1:0]                 irq;
  int                                          num_errors = 0;
  int                                          checks = 0;
  logic          [31:0]                        rv;
  logic                                        re;
  gpio_row_t                                   rows [13];
  logic          [4:0]                         modes [5];

  always #5 core_clk = ~core_clk;

  gpio_port_ctl gpio_port_ctl_inst (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_cfg(pad_cfg), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .irq(irq), .adc_trig(adc_trig));

  gpio_pad_model gpio_pad_model_inst (.core_clk(core_clk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_cfg(pad_cfg), .ext_val(ext_val), .ext_en(ext_en),
    .pad_in(pad_in));

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // ----------------------------------------------------------------
  // Bus access
  // ----------------------------------------------------------------
  task automatic apb(input logic [2:0] pt, input logic [11:0] off, input logic wr,
                     input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {pt, off};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [2:0] pt, input logic [11:0] off, input logic [31:0] d);
    apb(pt, off, 1'b1, d);
  endtask : wr

  task automatic rdchk(input logic [2:0] pt, input logic [11:0] off, input logic [31:0] exp,
                       input logic experr = 1'b0);
    apb(pt, off, 1'b0, 32'h0000_0000);
    `CHK(rv, exp)
    `CHK(re, experr)
  endtask : rdchk

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Whole run is about 400 cycles; this leaves ample margin
  initial begin
    idle(20000);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rows = '{'{3'd0, OFF_AFSEL, 32'h3F, 1'b0}, '{3'd0, OFF_DEN, 32'h3F, 1'b0},
             '{3'd0, OFF_PCTL, 32'h0011_1111, 1'b0}, '{3'd1, OFF_AFSEL, 32'h0C, 1'b0},
             '{3'd1, OFF_PCTL, 32'h0000_1100, 1'b0}, '{3'd2, OFF_PULLUP, 32'h0F, 1'b0},
             '{3'd2, OFF_PCTL, 32'h0000_3333, 1'b0}, '{3'd2, OFF_DEN, 32'h0F, 1'b0},
             '{3'd3, OFF_AFSEL, 32'h0, 1'b0}, '{3'd4, OFF_PULLDN, 32'h0, 1'b0},
             '{3'd1, OFF_DIR, 32'h0, 1'b0}, '{3'd0, 12'h800, 32'h0, 1'b1},
             '{3'd5, OFF_DIR, 32'h0, 1'b1}};
    // {sense, both, event, start level, end level}
    modes = '{5'b00101, 5'b00010, 5'b01001, 5'b10101, 5'b10010};
    idle(20);
    resetn <= 1'b1;
    idle(2);
    `CHK(pad_oe_n, {GPIO_NP*GPIO_NPIN{1'b1}})
    foreach (rows[i]) rdchk(rows[i].port, rows[i].off, rows[i].exp, rows[i].err);
    // Masked data writes and reads on port D
    wr(3'd3, OFF_DEN, 32'hFF);
    wr(3'd3, OFF_DIR, 32'hFF);
    wr(3'd3, 12'h098, 32'hEB);
    idle(2);
    `CHK(pad_out[3], 8'h22)
    `CHK(pad_oe_n[3], 8'h00)
    rdchk(3'd3, OFF_DATA_END, 32'h22);
    rdchk(3'd3, 12'h0C4, 32'h20);
    wr(3'd3, OFF_DEN, 32'h00);
    idle(2);
    `CHK(pad_oe_n[3], 8'hFF)
    `CHK(pad_cfg[3][0].analog, 1'b1)
    // Input capture, analog pins read zero
    ext_en[4]  <= 8'hFF;
    ext_val[4] <= 8'hA5;
    wr(3'd4, OFF_DEN, 32'h0F);
    idle(4);
    rdchk(3'd4, OFF_DATA_END, 32'h05);
    // Slew is asked for on both pins but only the 8 mA pin may get it
    wr(3'd4, OFF_DRIVE, {28'h000_0000, DRV_8MA, DRV_4MA});
    wr(3'd4, OFF_SLEW, 32'h0000_0003);
    wr(3'd4, OFF_ODRAIN, 32'h0000_0001);
    wr(3'd4, OFF_PULLDN, 32'h0000_0002);
    idle(2);
    `CHK(pad_cfg[4][1:0], {5'b00101, DRV_8MA, 5'b00010, DRV_4MA})
    // Peripheral takes pin D0 through mux code 2
    periph_out[3][0][1] <= 1'b1;
    periph_oe[3][0][1]  <= 1'b1;
    wr(3'd3, OFF_DEN, 32'h01);
    wr(3'd3, OFF_AFSEL, 32'h01);
    wr(3'd3, OFF_PCTL, 32'h2);
    idle(6);
    `CHK(pad_oe_n[3][1:0], 2'b10)
    `CHK(pad_out[3][0], 1'b1)
    `CHK(periph_in[3][0], 1'b1)
    wr(3'd3, OFF_PCTL, 32'h0);
    idle(2);
    `CHK(pad_oe_n[3][0], 1'b1)
    // Interrupt modes on pin B4, which also feeds the converter trigger
    // Enabled but undriven port B pins float and latch edges, so hold them all
    ext_en[1] <= 8'hFF;
    wr(3'd1, OFF_DEN, 32'h1C);
    foreach (modes[m]) begin
      wr(3'd1, OFF_IMASK, 32'h0);
      wr(3'd1, OFF_ISENSE, modes[m][4] ? 32'h10 : 32'h0);
      wr(3'd1, OFF_IBOTH, modes[m][3] ? 32'h10 : 32'h0);
      wr(3'd1, OFF_IEVENT, modes[m][2] ? 32'h10 : 32'h0);
      ext_val[1][4] <= modes[m][1];
      idle(8);
      wr(3'd1, OFF_ISTAT, 32'h0000_00FF);
      rdchk(3'd1, OFF_ISTAT, 32'h0);
      wr(3'd1, OFF_IMASK, 32'h10);
      ext_val[1][4] <= modes[m][0];
      idle(8);
      rdchk(3'd1, OFF_ISTAT, 32'h10);
      `CHK(irq[1], 1'b1)
      `CHK(adc_trig, 1'b1)
      wr(3'd1, OFF_IMASK, 32'h0);
      idle(2);
      `CHK({irq[1], adc_trig}, 2'b00)
      rdchk(3'd1, OFF_IMSTAT, 32'h0);
    end
    // Reset in mid-run restores defaults
    resetn <= 1'b0;
    idle(2);
    resetn <= 1'b1;
    idle(2);
    rdchk(3'd3, OFF_DEN, 32'h0);
    rdchk(3'd1, OFF_DEN, 32'h0C);
    tally_and_finish();
  end
endmodule : tb_gpio_port_pin_function_config
